// file: rtl/srw_unit.sv
// special register write unit: counters and status word updates
`timescale 1ns/1ps
module srw_unit
   import srw_pkg::*;
#(
   parameter int XDLY = srw_pkg::FLAG_DELAY
) (
   // clock and reset
   input  wire logic                       mclk,
   input  wire logic                       reset_n,
   // issued operation
   input  wire logic                       op_valid,
   input  wire logic [srw_pkg::OPC_W-1:0]  op_code,
   input  wire logic                       guard_present,
   input  wire logic [srw_pkg::DATA_W-1:0] guard_value,
   input  wire logic [srw_pkg::DATA_W-1:0] first_source_register,
   input  wire logic [srw_pkg::DATA_W-1:0] second_source_register,
   // interruptible jump
   input  wire logic                       ijump_valid,
   input  wire logic [srw_pkg::DATA_W-1:0] ijump_target,
   input  wire logic                       nmi_pending,
   input  wire logic                       int_pending,
   input  wire logic                       exception_event,
   // hardware status updates
   input  wire logic [srw_pkg::DATA_W-1:0] hw_status_mask,
   input  wire logic [srw_pkg::DATA_W-1:0] hw_status_value,
   // register views
   output logic      [srw_pkg::DATA_W-1:0] resume_target_counter,
   output logic      [srw_pkg::DATA_W-1:0] tree_source_counter,
   output logic      [srw_pkg::DATA_W-1:0] program_control_status_word,
   output logic      [srw_pkg::DATA_W-1:0] flag_view
);
   import srw_pkg::*;

   // all architectural state of the unit
   typedef struct packed {
      logic [DATA_W-1:0] resume;
      logic [DATA_W-1:0] source;
      logic [DATA_W-1:0] psw;
   } srw_state_t;

   srw_state_t        state_q;
   srw_state_t        state_d;
   logic              go;
   logic              wr_dst;
   logic              wr_src;
   logic              wr_psw;
   logic              quiet;
   logic [DATA_W-1:0] sw_psw;
   logic [DATA_W-1:0] flag_bits;

   // ==========================================
   // decode
   // the valid strobe is an argument so that every caller
   // re-evaluates when the strobe alone changes
   function automatic logic is_op(input logic             v,
                                  input logic [OPC_W-1:0] c,
                                  input logic [OPC_W-1:0] ref_c);
      return v && (c == ref_c);
   endfunction : is_op

   // no guard means unconditional, else guard lsb decides
   assign go     = !guard_present || guard_value[0];
   assign wr_dst = is_op(op_valid, op_code, OPC_WRITE_DST) && go;
   assign wr_src = is_op(op_valid, op_code, OPC_WRITE_SRC) && go;
   assign wr_psw = is_op(op_valid, op_code, OPC_WRITE_STATUS) && go;
   // any pending event marks the jump as interrupted
   assign quiet  = !(nmi_pending || int_pending || exception_event);
   // masked software merge
   assign sw_psw = (state_q.psw & ~second_source_register)
                 | (first_source_register & second_source_register);

   // ==========================================
   // next state
   always_comb begin
      state_d = state_q;
      // jump updates come first so a same-cycle software write wins
      if (ijump_valid) begin
         state_d.resume = ijump_target;
      end
      if (wr_dst) begin
         state_d.resume = first_source_register;
      end
      if (ijump_valid && quiet) begin
         state_d.source = ijump_target;
      end
      if (wr_src) begin
         state_d.source = first_source_register;
      end
      if (wr_psw) begin
         state_d.psw = sw_psw;
      end
      // hardware bits win over software bits
      state_d.psw = (state_d.psw & ~hw_status_mask)
                  | (hw_status_value & hw_status_mask);
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state_q.resume <= COUNTER_RST;
         state_q.source <= COUNTER_RST;
         state_q.psw    <= STATUS_RST;
      end else begin
         state_q <= state_d;
      end
   end

   assign resume_target_counter       = state_q.resume;
   assign tree_source_counter         = state_q.source;
   assign program_control_status_word = state_q.psw;

   // ==========================================
   // exception flag view seen by interrupt logic
   // only flag and enable bits travel down the delay line
   assign flag_bits = state_q.psw & FLAG_BITS_MASK;

   srw_delay #(
      .W     (DATA_W),
      .DEPTH (XDLY)
   ) u_dly (
      .mclk    (mclk),
      .reset_n (reset_n),
      .din     (flag_bits),
      .dout    (flag_view)
   );

   // ==========================================
   // assertions
   a_dst_write: assert property (
      @(posedge mclk) disable iff (!reset_n)
      wr_dst |=> resume_target_counter == $past(first_source_register))
      else $error("resume target write lost");

   a_dst_jump: assert property (
      @(posedge mclk) disable iff (!reset_n)
      ijump_valid && !wr_dst
      |=> resume_target_counter == $past(ijump_target))
      else $error("jump target not stored");

   a_src_write: assert property (
      @(posedge mclk) disable iff (!reset_n)
      wr_src |=> tree_source_counter == $past(first_source_register))
      else $error("tree source write lost");

   a_src_jump: assert property (
      @(posedge mclk) disable iff (!reset_n)
      ijump_valid && quiet && !wr_src
      |=> tree_source_counter == $past(ijump_target))
      else $error("quiet jump did not load source");

   a_src_hold_busy: assert property (
      @(posedge mclk) disable iff (!reset_n)
      ijump_valid && !quiet && !wr_src |=> $stable(tree_source_counter))
      else $error("interrupted jump moved source");

   a_guard_false: assert property (
      @(posedge mclk) disable iff (!reset_n)
      op_valid && guard_present && !guard_value[0] && !ijump_valid
      |=> $stable(resume_target_counter) && $stable(tree_source_counter))
      else $error("false guard wrote counter");

   a_psw_mask: assert property (
      @(posedge mclk) disable iff (!reset_n)
      wr_psw && hw_status_mask == '0 |=> program_control_status_word ==
      (($past(state_q.psw) & ~$past(second_source_register)) |
       ($past(first_source_register) & $past(second_source_register))))
      else $error("masked status write wrong");

   a_psw_hw_wins: assert property (
      @(posedge mclk) disable iff (!reset_n)
      1'b1 |=> ((program_control_status_word ^ $past(hw_status_value))
               & $past(hw_status_mask)) == '0)
      else $error("hardware bits not kept");

   a_no_guard: assert property (
      @(posedge mclk) disable iff (!reset_n)
      is_op(op_valid, op_code, OPC_WRITE_SRC) && !guard_present
      |=> tree_source_counter == $past(first_source_register))
      else $error("unguarded write ignored");

   a_unknown_op: assert property (
      @(posedge mclk) disable iff (!reset_n)
      op_valid && op_code != OPC_WRITE_DST && op_code != OPC_WRITE_SRC
      && op_code != OPC_WRITE_STATUS && !ijump_valid && hw_status_mask == '0
      |=> $stable(resume_target_counter) && $stable(tree_source_counter)
      && $stable(program_control_status_word))
      else $error("unknown opcode changed a register");

   a_flag_delay: assert property (
      @(posedge mclk) disable iff (!reset_n)
      wr_psw ##1 1'b1[*3] |-> flag_view ==
      ($past(program_control_status_word, 3) & FLAG_BITS_MASK))
      else $error("exception view delay wrong");

   // every view reads its reset value the cycle after a reset edge
   a_reset_clear: assert property (
      @(posedge mclk)
      !reset_n |=> resume_target_counter == COUNTER_RST
      && tree_source_counter == COUNTER_RST
      && program_control_status_word == STATUS_RST && flag_view == '0)
      else $error("reset left a register set");

   // ==========================================
   // cover points
   c_dst_clash: cover property (@(posedge mclk) wr_dst && ijump_valid);
   c_src_clash: cover property (@(posedge mclk) wr_src && ijump_valid);
   c_psw_hw: cover property (@(posedge mclk) wr_psw && hw_status_mask != '0);
   c_guard_off: cover property (@(posedge mclk)
      op_valid && guard_present && !guard_value[0]);
   c_src_busy: cover property (@(posedge mclk) ijump_valid && !quiet);
endmodule : srw_unit

// file: rtl/srw_pkg.sv
// shared constants for the special register write unit
package srw_pkg;
   // ==========================================
   // widths
   localparam int DATA_W   = 32;
   localparam int OPC_W    = 8;
   // ==========================================
   // operation codes
   localparam logic [7:0] OPC_WRITE_SRC   = 8'h9f;
   localparam logic [7:0] OPC_WRITE_DST   = 8'ha0;
   localparam logic [7:0] OPC_WRITE_STATUS = 8'ha1;
   // ==========================================
   // reset values and timing
   localparam logic [31:0] COUNTER_RST    = 32'h0000_0000;
   localparam logic [31:0] STATUS_RST     = 32'h0000_0000;
   localparam int          FLAG_DELAY     = 3;
   // exception flag and enable bits of the status word (plain default)
   localparam logic [31:0] FLAG_BITS_MASK = 32'hffff_00ff;
endpackage : srw_pkg

// file: rtl/srw_delay.sv
// fixed-latency delay line for the exception view of the status word
`timescale 1ns/1ps
module srw_delay #(
   parameter int W     = 32,
   parameter int DEPTH = 3
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         reset_n,
   // data
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] stage;
   } srw_dly_state_t;

   srw_dly_state_t state_q;
   srw_dly_state_t state_d;

   always_comb begin
      state_d = state_q;
      state_d.stage[0] = din;
      for (int i = 1; i < DEPTH; i++) begin
         state_d.stage[i] = state_q.stage[i-1];
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign dout = state_q.stage[DEPTH-1];
endmodule : srw_delay

// file: dv/srw_issue.sv
// issue slot model that places operations into the unit
`timescale 1ns/1ps
module srw_issue (
   // clock
   input  wire logic  mclk,
   // issued operation
   output logic        op_valid,
   output logic [7:0]  op_code,
   output logic        guard_present,
   output logic [31:0] guard_value,
   output logic [31:0] src1,
   output logic [31:0] src2
);
   initial begin
      {op_valid, op_code, guard_present} = '0;
      {guard_value, src1, src2} = '0;
   end
   // one op for one cycle, called just after a falling edge
   task automatic issue(input logic [7:0] c, input logic g,
                        input logic [31:0] gv, s1, s2);
      {op_valid, op_code, guard_present} = {1'b1, c, g};
      {guard_value, src1, src2} = {gv, s1, s2};
      @(posedge mclk);
      // released fields no longer show the last value
      op_valid <= 1'b0;
      {src1, src2, guard_value} <= ~{s1, s2, gv};
      @(negedge mclk);
   endtask : issue
endmodule : srw_issue

// file: dv/srw_unit_tb.sv
// self-checking bench for the special register write unit
`timescale 1ns/1ps
module srw_unit_tb;
   import srw_pkg::*;
   logic        mclk = 1'b0;
   logic        reset_n = 1'b0;
   logic        op_valid, guard_present, ijv, nmi, intp, excp;
   logic [7:0]  op_code;
   logic [31:0] guard_value, src1, src2, ijt, hwm, hwv, rtc, tsc, psw, xv;
   int          miscompares = 0;
   int          checks_done = 0;
   always #4 mclk = ~mclk;
   srw_issue issue_u (.mclk(mclk), .op_valid(op_valid), .op_code(op_code),
      .guard_present(guard_present), .guard_value(guard_value),
      .src1(src1), .src2(src2));
   srw_unit dut_u (.mclk(mclk), .reset_n(reset_n), .op_valid(op_valid),
      .op_code(op_code), .guard_present(guard_present),
      .guard_value(guard_value), .first_source_register(src1),
      .second_source_register(src2), .ijump_valid(ijv), .ijump_target(ijt),
      .nmi_pending(nmi), .int_pending(intp), .exception_event(excp),
      .hw_status_mask(hwm), .hw_status_value(hwv),
      .resume_target_counter(rtc), .tree_source_counter(tsc),
      .program_control_status_word(psw), .flag_view(xv));
   task automatic chk(input logic [31:0] seen, exp, input string m);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : finish_test
   task automatic t_writes();
      chk(rtc | tsc | psw | xv, 32'h0, "reset state");
      issue_u.issue(8'h9e, 1'b0, 32'h0, '1, '1);
      chk(rtc | tsc | psw, 32'h0, "unknown opcode");
      issue_u.issue(OPC_WRITE_DST, 1'b0, 32'h0, 32'h00be_ebee, 32'h0);
      chk(rtc, 32'h00be_ebee, "resume write");
      issue_u.issue(OPC_WRITE_SRC, 1'b0, 32'h0, 32'h0000_abba, 32'h0);
      chk(tsc, 32'h0000_abba, "source write");
      issue_u.issue(OPC_WRITE_DST, 1'b1, 32'hffff_fffe, 32'h1234_5678, 32'h0);
      chk(rtc, 32'h00be_ebee, "false guard");
      issue_u.issue(OPC_WRITE_SRC, 1'b1, 32'h1, 32'h1234_5678, 32'h0);
      chk(tsc, 32'h1234_5678, "true guard");
      issue_u.issue(OPC_WRITE_STATUS, 1'b1, 32'h0, '1, '1);
      chk(psw, 32'h0, "false guard status");
   endtask : t_writes
   task automatic t_program_control_status_word();
      // masks stay on defined fields
      issue_u.issue(OPC_WRITE_STATUS, 1'b0, 32'h0,
                    32'h8011_0100, 32'hffff_0180);
      chk(psw, 32'h8011_0100, "masked write");
      repeat (FLAG_DELAY - 1) @(negedge mclk);
      chk(xv, 32'h0, "flags early");
      @(negedge mclk);
      chk(xv, 32'h8011_0100 & FLAG_BITS_MASK, "flags late");
      {hwm, hwv} = {32'h0000_00ff, 32'h0000_0055};
      issue_u.issue(OPC_WRITE_STATUS, 1'b0, 32'h0,
                    32'h0000_00aa, 32'h0000_0fff);
      {hwm, hwv} = '0;
      chk(psw, 32'h8011_0055, "hardware wins");
   endtask : t_program_control_status_word
   task automatic t_jump();
      repeat (3) @(negedge mclk);
      for (int i = 0; i < 4; i++) begin
         {nmi, intp, excp} = (i < 3) ? 3'b100 >> i : 3'b000;
         {ijv, ijt} = {1'b1, 32'h0000_1000 + 32'(i)};
         @(negedge mclk);
         ijv = 1'b0;
         chk(rtc, 32'h0000_1000 + 32'(i), "jump resume");
         chk(tsc, (i < 3) ? 32'h1234_5678 : 32'h1003, "jump src");
      end
   endtask : t_jump
   task automatic t_collide();
      {ijv, ijt} = {1'b1, 32'h0000_2000};
      issue_u.issue(OPC_WRITE_DST, 1'b0, 32'h0, 32'h0000_dead, 32'h0);
      chk(rtc, 32'h0000_dead, "resume collide");
      chk(tsc, 32'h0000_2000, "src by jump");
      issue_u.issue(OPC_WRITE_SRC, 1'b0, 32'h0, 32'h0000_beef, 32'h0);
      ijv = 1'b0;
      chk(tsc, 32'h0000_beef, "src collide");
      chk(rtc, 32'h0000_2000, "resume by jump");
   endtask : t_collide
   task automatic t_reset();
      // a hardware update during reset must not reach the status word
      {hwm, hwv} = {32'h0000_00ff, 32'h0000_0033};
      reset_n = 1'b0;
      repeat (2) @(negedge mclk);
      chk(rtc | tsc | psw | xv, 32'h0, "mid-run reset");
      {hwm, hwv} = '0;
      reset_n = 1'b1;
      @(negedge mclk);
      issue_u.issue(OPC_WRITE_DST, 1'b1, 32'h1, 32'h0000_0abc, 32'h0);
      chk(rtc, 32'h0000_0abc, "write after reset");
      chk(psw, 32'h0, "status after reset");
   endtask : t_reset
   initial begin
      {ijv, nmi, intp, excp} = '0;
      {ijt, hwm, hwv} = '0;
      repeat (2) @(negedge mclk);
      reset_n = 1'b1;
      @(negedge mclk);
      t_writes();
      t_program_control_status_word();
      t_jump();
      t_collide();
      t_reset();
      finish_test();
   end
   initial begin
      #100000;
      miscompares++;
      finish_test();
   end
endmodule : srw_unit_tb
